//--- verilog/vscd_pkg.sv
// Constants, register map and types of the link status monitor
package vscd_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Clock presence window and threshold
    localparam int unsigned DETECT_SET_MAX_NS = 10000;
    localparam int unsigned DETECT_WINDOW_CYC = DETECT_SET_MAX_NS / (3 * CLK_PERIOD_NS);
    localparam int unsigned DETECT_MIN_EDGES = 8;
    localparam int unsigned DETECT_EDGE_MAX = 63;
    // Output clock stop after link clock stops
    localparam int unsigned OUTCLK_STOP_MAX_NS = 100;
    localparam int unsigned OUTCLK_STOP_CYC = OUTCLK_STOP_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned LINK_IDLE_CYC = OUTCLK_STOP_CYC - 5;
    // Data-enable timing, in link clock cycles
    localparam int unsigned DE_HIGH_CYC = 4096;
    localparam int unsigned DE_LOW_CYC = 1000000;
    localparam int unsigned DE_EDGES_SET = 4;
    localparam int unsigned DE_RUN_MAX = 1048575;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
    // Control bits
    localparam int unsigned CTRL_SOFT_RESET = 0;
    localparam int unsigned CTRL_POWER_DOWN = 1;
    localparam int unsigned CTRL_DUAL_EDGE = 2;
    localparam int unsigned CTRL_CLK_INVERT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // Status bits
    localparam int unsigned STAT_CLOCK_DETECT = 0;
    localparam int unsigned STAT_SYNC_DETECT = 1;
    // Interrupt bits, and the data half width of dual-edge launch
    localparam int unsigned INT_CLOCK_RISE = 0;
    localparam int unsigned INT_CLOCK_FALL = 1;
    localparam int unsigned INT_SYNC_RISE = 2;
    localparam int unsigned INT_SYNC_FALL = 3;
    localparam logic [3:0] INT_RST = 4'h0;
    localparam int unsigned HALF_WIDTH = 18;

    typedef enum logic [1:0] {
        SD_IDLE,
        SD_ACQUIRE,
        SD_LOCKED
    } vscd_sync_state_t;
endpackage

//--- verilog/vscd_sync2.sv
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
module vscd_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

//--- verilog/vscd_top.sv
// Link status monitor: clock and sync detection, interrupt, output clock and launch
//
// Overview of operation
// RL1: Sync-detect clears after data-enable stays high about 4096 pixel clocks.
// RL2: Sync-detect clears after data-enable stays low about one million pixel clocks.
// RL3: Sync-detect sets after clock detect plus at least four data-enable edges.
// RL4: Data-enable stuck high with running link clock drops sync-detect.
// RL5: Clock-detect clears within 100 us of the link clock stopping.
// RL6: Clock-detect sets within 10 us of the link clock starting.
// RL7: Both flags readable; sync-detect only with clock-detect, falls with it.
// RL8: Enabled flag set or clear changes the interrupt within 100 us.
// RL9: In power-down the interrupt follows the sync-detect state.
// RL10: Pixel output clock stops within 100 ns of link clock stopping.
// RL11: Pixel output clock runs within 10 ms; sync-detect marks stable timing.
// RL12: Host pulses the soft reset bit within 100 ms after sync-detect rises.
// RL13: Host holds hardware reset low the minimum time before register access.
// RL14: Minimum valid hardware reset low time is 50 us.
// RL15: Single-edge modes launch on one edge; invert bit picks the other edge.
// RL16: Dual-edge modes launch data halves on both output clock edges.
// RL17: Clock presence is an edge count over a fixed reference window.
`timescale 1ns/1ns
module vscd_top #(
    parameter int unsigned DE_LOW_CYC = vscd_pkg::DE_LOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic link_input_clock,
    input wire logic link_de,
    input wire logic [35:0] pixel_data_in,
    input wire logic [2:0] pixel_sync_in,
    output logic pixel_output_clock,
    output logic [35:0] pixel_data_out,
    output logic [2:0] pixel_sync_out,
    output logic irq
);
    logic [1:0] link_sync;
    logic lc_s;
    logic de_s;
    logic lc_d;
    logic link_rise;
    logic link_fall;
    logic [2:0] idle_cnt;
    logic link_active;
    logic [8:0] win_cnt;
    logic win_end;
    logic [5:0] edge_cnt;
    logic clock_detect_flag;
    logic clock_detect_d;
    logic de_prev;
    logic de_edge;
    logic [19:0] de_run;
    logic de_high_timeout;
    logic de_low_timeout;
    logic [2:0] de_edges;
    vscd_pkg::vscd_sync_state_t sync_state;
    logic sync_detect_flag;
    logic sync_detect_d;
    logic [3:0] ctrl;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    logic [3:0] int_events;
    logic soft_reset_bit;
    logic power_down;
    logic dual_edge_mode;
    logic output_clock_invert;
    logic launch;
    logic wb_req;
    logic wb_wr;

    function automatic logic cnt_done(input logic [19:0] cnt, input int unsigned limit);
        cnt_done = (cnt == 20'(limit - 1));
    endfunction

    assign soft_reset_bit = ctrl[vscd_pkg::CTRL_SOFT_RESET];
    assign power_down = ctrl[vscd_pkg::CTRL_POWER_DOWN];
    assign dual_edge_mode = ctrl[vscd_pkg::CTRL_DUAL_EDGE];
    assign output_clock_invert = ctrl[vscd_pkg::CTRL_CLK_INVERT];

    vscd_sync2 #(
        .WIDTH(2)
    ) u_link_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({link_de, link_input_clock}),
        .sync_out(link_sync)
    );

    assign lc_s = link_sync[0];
    assign de_s = link_sync[1];
    assign link_rise = lc_s & ~lc_d;
    assign link_fall = ~lc_s & lc_d;

    // Link clock edge finder and idle timer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lc_d <= 1'b0;
            idle_cnt <= '0;
        end
        else
        begin
            lc_d <= lc_s;
            if (lc_s != lc_d)
                idle_cnt <= '0;
            else if (idle_cnt != 3'(vscd_pkg::LINK_IDLE_CYC))
                idle_cnt <= idle_cnt + 3'd1;
        end
    end

    assign link_active = (idle_cnt != 3'(vscd_pkg::LINK_IDLE_CYC));

    // Gated copy of the link clock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pixel_output_clock <= 1'b0;
        else
            pixel_output_clock <= link_active & lc_s; // [RL10] [RL11]
    end

    // Edge count over a fixed reference window
    assign win_end = (win_cnt == 9'(vscd_pkg::DETECT_WINDOW_CYC - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_cnt <= '0;
            edge_cnt <= '0;
            clock_detect_flag <= 1'b0;
        end
        else if (soft_reset_bit)
        begin
            win_cnt <= '0;
            edge_cnt <= '0;
            clock_detect_flag <= 1'b0;
        end
        else if (win_end)
        begin
            win_cnt <= '0;
            edge_cnt <= '0;
            clock_detect_flag <= (edge_cnt >= 6'(vscd_pkg::DETECT_MIN_EDGES)); // [RL5] [RL6] [RL17]
        end
        else
        begin
            win_cnt <= win_cnt + 9'd1;
            if (link_rise && edge_cnt != 6'(vscd_pkg::DETECT_EDGE_MAX))
                edge_cnt <= edge_cnt + 6'd1;
        end
    end

    // Data-enable run length, in link clock cycles
    assign de_edge = link_rise & (de_s != de_prev);
    assign de_high_timeout = link_rise & de_s & de_prev & cnt_done(de_run, vscd_pkg::DE_HIGH_CYC);
    assign de_low_timeout = link_rise & ~de_s & ~de_prev & cnt_done(de_run, DE_LOW_CYC);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            de_prev <= 1'b0;
            de_run <= '0;
        end
        else if (soft_reset_bit)
        begin
            de_prev <= 1'b0;
            de_run <= '0;
        end
        else if (link_rise)
        begin
            de_prev <= de_s;
            if (de_s != de_prev)
                de_run <= '0;
            else if (de_run != 20'(vscd_pkg::DE_RUN_MAX))
                de_run <= de_run + 20'd1;
        end
    end

    // Sync detection sequence
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_state <= vscd_pkg::SD_IDLE;
            de_edges <= '0;
        end
        else if (soft_reset_bit || !clock_detect_flag)
        begin
            sync_state <= vscd_pkg::SD_IDLE; // [RL7]
            de_edges <= '0;
        end
        else
        begin
            case (sync_state)
                vscd_pkg::SD_IDLE:
                begin
                    sync_state <= vscd_pkg::SD_ACQUIRE;
                    de_edges <= '0;
                end
                vscd_pkg::SD_ACQUIRE:
                begin
                    if (de_edge)
                    begin
                        de_edges <= de_edges + 3'd1;
                        if (de_edges == 3'(vscd_pkg::DE_EDGES_SET - 1))
                            sync_state <= vscd_pkg::SD_LOCKED; // [RL3]
                    end
                end
                vscd_pkg::SD_LOCKED:
                begin
                    if (de_high_timeout || de_low_timeout)
                    begin
                        sync_state <= vscd_pkg::SD_ACQUIRE; // [RL1] [RL2] [RL4]
                        de_edges <= '0;
                    end
                end
                default:
                begin
                    sync_state <= vscd_pkg::SD_IDLE;
                    de_edges <= '0;
                end
            endcase
        end
    end

    // Gated by clock detect so both flags fall in the same cycle
    assign sync_detect_flag = (sync_state == vscd_pkg::SD_LOCKED) & clock_detect_flag; // [RL7]

    // Flag change events
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_detect_d <= 1'b0;
            sync_detect_d <= 1'b0;
        end
        else
        begin
            clock_detect_d <= clock_detect_flag;
            sync_detect_d <= sync_detect_flag;
        end
    end

    always_comb
    begin
        int_events = '0;
        int_events[vscd_pkg::INT_CLOCK_RISE] = clock_detect_flag & ~clock_detect_d;
        int_events[vscd_pkg::INT_CLOCK_FALL] = ~clock_detect_flag & clock_detect_d;
        int_events[vscd_pkg::INT_SYNC_RISE] = sync_detect_flag & ~sync_detect_d;
        int_events[vscd_pkg::INT_SYNC_FALL] = ~sync_detect_flag & sync_detect_d;
    end

    // Wishbone slave, one wait state
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    vscd_pkg::ADDR_CTRL: wb_dat_o <= {28'h000_0000, ctrl};
                    vscd_pkg::ADDR_STATUS: wb_dat_o <= {30'h0000_0000, sync_detect_flag, clock_detect_flag}; // [RL7]
                    vscd_pkg::ADDR_INT_STATUS: wb_dat_o <= {28'h000_0000, int_status};
                    vscd_pkg::ADDR_INT_MASK: wb_dat_o <= {28'h000_0000, int_mask};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl <= vscd_pkg::CTRL_RST;
        else if (wb_wr && wb_adr_i == vscd_pkg::ADDR_CTRL)
            ctrl <= wb_dat_i[3:0]; // [RL12]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            int_mask <= vscd_pkg::INT_RST;
        else if (wb_wr && wb_adr_i == vscd_pkg::ADDR_INT_MASK)
            int_mask <= wb_dat_i[3:0];
    end

    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            int_status <= vscd_pkg::INT_RST;
        else if (wb_wr && wb_adr_i == vscd_pkg::ADDR_INT_STATUS)
            int_status <= (int_status & ~wb_dat_i[3:0]) | int_events;
        else
            int_status <= int_status | int_events;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else if (power_down)
            irq <= sync_detect_flag; // [RL9]
        else
            irq <= |(int_status & int_mask); // [RL8]
    end

    // Pixel launch on the selected output clock edges
    assign launch = link_active & (dual_edge_mode ? (link_rise | link_fall)
                                                  : (output_clock_invert ? link_fall : link_rise));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pixel_data_out <= '0;
            pixel_sync_out <= '0;
        end
        else if (launch)
        begin
            pixel_sync_out <= pixel_sync_in;
            if (!dual_edge_mode)
                pixel_data_out <= pixel_data_in; // [RL15]
            else if (link_rise)
                pixel_data_out <= {18'h0_0000, pixel_data_in[vscd_pkg::HALF_WIDTH-1:0]}; // [RL16]
            else
                pixel_data_out <= {18'h0_0000, pixel_data_in[35:vscd_pkg::HALF_WIDTH]}; // [RL16]
        end
    end

    // Checks
    default clocking chk_clk @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sync_needs_clock_a: assert property (sync_detect_flag |-> clock_detect_flag) // [RL7]
        else $error("sync detect high without clock detect");
    sync_falls_clock_a: assert property ($fell(clock_detect_flag) |=> !sync_detect_flag) // [RL7]
        else $error("sync detect did not fall with clock detect");
    sync_set_edges_a: assert property ($rose(sync_detect_flag) |-> $past(de_edge) && $past(de_edges) == 3'd3) // [RL3]
        else $error("sync detect set without four edges");
    de_high_clear_a: assert property (sync_detect_flag && de_high_timeout |=> !sync_detect_flag) // [RL1]
        else $error("sync detect not cleared after long high enable");
    de_low_clear_a: assert property (sync_detect_flag && de_low_timeout |=> !sync_detect_flag) // [RL2]
        else $error("sync detect not cleared after long low enable");
    clock_window_a: assert property (win_end && !soft_reset_bit |=>
            clock_detect_flag == ($past(edge_cnt) >= 6'd8)) // [RL5]
        else $error("clock detect does not match window count");
    clock_steady_a: assert property (!win_end && !soft_reset_bit |=> $stable(clock_detect_flag)) // [RL17]
        else $error("clock detect changed outside window end");
    outclk_stop_a: assert property (idle_cnt == 3'd5 |=> !pixel_output_clock) // [RL10]
        else $error("output clock still running after link stopped");
    irq_power_a: assert property (power_down && $stable(power_down) |=> irq == $past(sync_detect_flag)) // [RL9]
        else $error("interrupt does not follow sync detect in power down");
    irq_mask_a: assert property (!power_down && (int_status & int_mask) != 4'h0 |=> irq) // [RL8]
        else $error("masked interrupt not raised");
    launch_edge_a: assert property (!dual_edge_mode && !output_clock_invert && $stable(ctrl) && $changed(pixel_data_out)
            |-> $past(link_rise)) // [RL15]
        else $error("single edge data launched on wrong edge");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge held longer than one cycle");

    sync_lock_c: cover property ($rose(sync_detect_flag));
    clock_loss_c: cover property ($fell(clock_detect_flag));
    dual_launch_c: cover property (launch && dual_edge_mode && link_fall);
    irq_raise_c: cover property ($rose(irq) && !power_down);
endmodule

//--- sim/vscd_link_model.sv
// Far-side link model: gated link clock and data-enable patterns
`timescale 1ns/1ns
module vscd_link_model (
    input wire logic run,
    input wire logic [1:0] de_mode,
    output logic link_input_clock,
    output logic link_de
);
    int unsigned de_cnt;

    // Clock stands low between frames, phase offset from the system clock
    initial
    begin
        link_input_clock = 1'b0;
        #3;
        forever
        begin
            #40;
            if (run)
                link_input_clock = ~link_input_clock;
            else
                link_input_clock = 1'b0;
        end
    end

    // Modes: 0 stuck low, 1 stuck high, 2 toggle every 8 link cycles
    initial
    begin
        link_de = 1'b0;
        de_cnt = 0;
    end

    always @(posedge link_input_clock)
    begin
        de_cnt = de_cnt + 1;
        if (de_mode == 2'd0)
            link_de = 1'b0;
        else if (de_mode == 2'd1)
            link_de = 1'b1;
        else if (de_cnt % 8 == 0)
            link_de = ~link_de;
    end
endmodule

//--- sim/tb_video_sync_clock_detect_irq.sv
// Testbench of the link status monitor
`timescale 1ns/1ns
module tb_video_sync_clock_detect_irq;
    logic clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, run, poc, irq, lclk, lde;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic [1:0] de_mode;
    logic [35:0] pix_in, pix_out;
    logic [2:0] sync_in, sync_out;
    int n_errors, total_checks;

    vscd_top #(.DE_LOW_CYC(50)) u_dut (.clk(clk), .rst_n(rst_n), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
        .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_ack_o(wb_ack),
        .wb_dat_o(wb_rdat), .link_input_clock(lclk), .link_de(lde), .pixel_data_in(pix_in),
        .pixel_sync_in(sync_in), .pixel_output_clock(poc), .pixel_data_out(pix_out),
        .pixel_sync_out(sync_out), .irq(irq));

    vscd_link_model u_link (.run(run), .de_mode(de_mode), .link_input_clock(lclk), .link_de(lde));

    initial
    begin
        clk = 1'b0;
        forever
            #5 clk = ~clk;
    end

    task automatic test_done();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [38:0] exp, input logic [38:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [31:0] wd, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        wb_sel <= 4'hf;
        do
        begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        d = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (n >= 50)
            chk("bus ack", 39'h1, 39'h0);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        wb_xfer(adr, 1'b1, wd, d);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(adr, 1'b0, 32'h0000_0000, rd);
        chk(name, 39'(exp), 39'(rd));
    endtask

    // Poll one status bit until it reaches the level or the cycle budget runs out
    task automatic wait_stat(input int b, input logic v, input int max_cyc);
        int t;
        t = 0;
        do
        begin
            wb_xfer(vscd_pkg::ADDR_STATUS, 1'b0, 32'h0000_0000, rd);
            t += 3;
        end while (rd[b] !== v && t < max_cyc);
        chk("status bit", 39'(v), 39'(rd[b]));
    endtask

    task automatic irq_chk(input logic v);
        repeat (3) @(posedge clk);
        chk("irq", 39'(v), 39'(irq));
    endtask

    // Old word must hold through the other edge, new word lands on the launch edge
    task automatic launch_single(input logic inv, input logic [35:0] nd);
        logic [38:0] old;
        wr(vscd_pkg::ADDR_CTRL, 32'(inv) << vscd_pkg::CTRL_CLK_INVERT);
        repeat (3) @(posedge poc);
        if (inv) @(negedge poc); else @(posedge poc);
        @(negedge clk);
        old = {sync_out, pix_out};
        @(posedge clk);
        pix_in <= nd;
        sync_in <= nd[2:0];
        if (inv) @(posedge poc); else @(negedge poc);
        @(negedge clk);
        chk("launch hold", old, {sync_out, pix_out});
        if (inv) @(negedge poc); else @(posedge poc);
        @(negedge clk);
        chk("launch new", {nd[2:0], nd}, {sync_out, pix_out});
    endtask

    initial
    begin
        #900000;
        n_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        test_done();
    end

    initial
    begin
        rst_n = 1'b0;
        {wb_cyc, wb_stb, wb_we, run} = 4'h0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_wdat = 32'h0000_0000;
        de_mode = 2'd2;
        pix_in = 36'h0_0000_0000;
        sync_in = 3'h0;
        n_errors = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd_chk("reset value", 8'(i * 4), 32'h0000_0000);
        wr(8'h10, 32'h0000_000f);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
        wr(vscd_pkg::ADDR_INT_MASK, 32'h0000_000f);
        rd_chk("int mask", vscd_pkg::ADDR_INT_MASK, 32'h0000_000f);
        run = 1'b1;
        wait_stat(0, 1'b1, 1000);
        wait_stat(1, 1'b1, 2000);
        rd_chk("int rise", vscd_pkg::ADDR_INT_STATUS, 32'h0000_0005);
        irq_chk(1'b1);
        wr(vscd_pkg::ADDR_INT_MASK, 32'h0000_0000);
        irq_chk(1'b0);
        wr(vscd_pkg::ADDR_INT_MASK, 32'h0000_000f);
        wr(vscd_pkg::ADDR_INT_STATUS, 32'h0000_0005);
        rd_chk("int clear", vscd_pkg::ADDR_INT_STATUS, 32'h0000_0000);
        irq_chk(1'b0);
        wr(vscd_pkg::ADDR_CTRL, 32'h0000_0001);
        rd_chk("soft reset", vscd_pkg::ADDR_STATUS, 32'h0000_0000);
        wr(vscd_pkg::ADDR_CTRL, 32'h0000_0000);
        wait_stat(1, 1'b1, 2000);
        launch_single(1'b0, 36'h5_a5a5_3c3c);
        launch_single(1'b1, 36'ha_5a5a_c3c4);
        wr(vscd_pkg::ADDR_CTRL, 32'h0000_0004);
        pix_in <= 36'h9_8765_4321;
        sync_in <= 3'h1;
        repeat (2) @(posedge poc);
        @(negedge clk);
        chk("dual low", {3'h1, 18'h0_0000, 18'h1_4321}, {sync_out, pix_out});
        @(negedge poc);
        @(negedge clk);
        chk("dual high", {3'h1, 18'h0_0000, 18'h2_61d9}, {sync_out, pix_out});
        wr(vscd_pkg::ADDR_CTRL, 32'h0000_0002);
        irq_chk(1'b1);
        de_mode = 2'd1;
        wait_stat(1, 1'b0, 4096 * 8 + 2000);
        irq_chk(1'b0);
        de_mode = 2'd2;
        wait_stat(1, 1'b1, 2000);
        irq_chk(1'b1);
        de_mode = 2'd0;
        wait_stat(1, 1'b0, 50 * 8 + 1000);
        de_mode = 2'd2;
        wait_stat(1, 1'b1, 2000);
        wr(vscd_pkg::ADDR_CTRL, 32'h0000_0000);
        wr(vscd_pkg::ADDR_INT_STATUS, 32'h0000_000f);
        run = 1'b0;
        repeat (12) @(posedge clk);
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk);
            chk("output clock idle", 39'h0, 39'(poc));
        end
        wait_stat(0, 1'b0, 10000);
        rd_chk("flags idle", vscd_pkg::ADDR_STATUS, 32'h0000_0000);
        rd_chk("int fall", vscd_pkg::ADDR_INT_STATUS, 32'h0000_000a);
        irq_chk(1'b1);
        test_done();
    end
endmodule
